// ### dv/ais_host_model.sv
// Host model that issues register read and write commands to the bank.
// Assumes the bank takes a command at a rising edge and answers a read one cycle later.
`default_nettype none
module ais_host_model (
	// Clock.
	input wire logic clk_i,
	// Command port toward the bank.
	output logic rd_o,
	output logic wr_o,
	output logic [7:0] addr_o,
	output logic [7:0] wdata_o,
	input wire logic [7:0] rdata_i,
	input wire logic rvalid_i
);
	timeunit 1ns;
	timeprecision 100ps;

	// Idle bus at time zero.
	initial begin
		rd_o = 1'b0;
		wr_o = 1'b0;
		addr_o = 8'hFF;
		wdata_o = 8'hFF;
	end

	// One write, held across one rising edge; lines are inverted afterwards so stale data never matches.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_i);
		wr_o = 1'b1;
		addr_o = a;
		wdata_o = d;
		@(negedge clk_i);
		wr_o = 1'b0;
		addr_o = ~a;
		wdata_o = ~d;
	endtask : wr

	// One read; data and valid are taken in the cycle after the command.
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(negedge clk_i);
		rd_o = 1'b1;
		addr_o = a;
		@(negedge clk_i);
		rd_o = 1'b0;
		addr_o = ~a;
		d = rdata_i;
		v = rvalid_i;
	endtask : rd
endmodule : ais_host_model
`default_nettype wire

// ### dv/test_ais_regs.sv
// Self-checking bench for the identification, status and input select bank.
// Assumes the host model drives the command port and monitors settle within eight cycles.
`default_nettype none
module test_ais_regs;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {logic [7:0] a; logic [7:0] w; logic [7:0] m; logic [7:0] e;} ais_row_t;
	localparam logic [2:0] MODEL = 3'h6; // Arbitrary model code.
	logic core_clk = 1'b1;
	logic rst = 1'b0;
	logic rd, wr, rvalid;
	logic rail_en = 1'b0;
	logic [1:0] ref_en = 2'b00;
	logic [6:0] mon = 7'h00;
	logic [7:0] addr, wdata, rdata;
	logic [3:0] psel, nsel;
	int miscompares = 0;
	int tests_run = 0;
	// Address, write data, read mask, expected read.
	ais_row_t rows [9] = '{'{8'h02, 8'hA5, 8'hFF, 8'hA5}, '{8'h02, 8'hFC, 8'hFF, 8'hFC},
		'{8'h02, 8'h0B, 8'hFF, 8'h0B}, '{8'h00, 8'hFF, 8'h07, {5'h00, MODEL}},
		'{8'h01, 8'h80, 8'hFF, 8'h80}, '{8'h01, 8'h7F, 8'hFF, 8'h00},
		'{8'h01, 8'h80, 8'hFF, 8'h80}, '{8'h01, 8'h7F, 8'hFF, 8'h00},
		'{8'h03, 8'h5A, 8'hFF, 8'h00}};

	// Clock of 25 ns period, starting high so a falling edge comes before any rising edge.
	always #12.5 core_clk = ~core_clk;

	ais_regs #(.MODEL_CODE(MODEL), .ID_RESERVED(5'h00)) dut_u (.core_clk_i(core_clk),
		.rst_i(rst), .reg_rd_i(rd), .reg_wr_i(wr), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .rail_monitor_enable_i(rail_en),
		.reference_monitor_enable_i(ref_en), .pos_out_high_rail_i(mon[5]),
		.pos_out_low_rail_i(mon[4]), .neg_out_high_rail_i(mon[3]), .neg_out_low_rail_i(mon[2]),
		.reference_third_supply_i(mon[1]), .reference_missing_i(mon[0]),
		.not_ready_i(mon[6]), .positive_input_select_o(psel), .negative_input_select_o(nsel));

	ais_host_model host_u (.clk_i(core_clk), .rd_o(rd), .wr_o(wr), .addr_o(addr),
		.wdata_o(wdata), .rdata_i(rdata), .rvalid_i(rvalid));

	// Counts a comparison and reports a mismatch.
	task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : cmp

	// Reads one register and checks valid and masked data.
	task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [7:0] d;
		logic v;
		host_u.rd(a, d, v);
		cmp("rvalid", 8'h01, {7'h00, v});
		cmp("rdata", e, d & m);
		@(negedge core_clk);
		cmp("rvalid_drop", 8'h00, {7'h00, rvalid});
	endtask : rchk

	// Checks the values that follow a reset.
	task automatic dflt();
		rchk(8'h01, 8'hFF, 8'h80);
		rchk(8'h02, 8'hFF, 8'h01);
		cmp("select", 8'h01, {psel, nsel});
	endtask : dflt

	// Applies monitor levels and enables, then reads the status with gating worked out here.
	task automatic mchk(input logic re, input logic [1:0] fe, input logic [6:0] m);
		logic [7:0] e;
		rail_en = re;
		ref_en = fe;
		mon = m;
		e = {1'b0, m[6], m[5:2] & {4{re}}, m[1] & fe[1], m[0] & (|fe)};
		repeat (8) @(negedge core_clk);
		rchk(8'h01, 8'hFF, e);
	endtask : mchk

	// Prints the counts and the verdict, then ends the run.
	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : report_and_stop

	// Main sequence: reset, table of write and read rows, monitors, reset in mid-run.
	initial begin
		// Raise reset on a real edge so the asynchronous branch loads the defaults.
		@(negedge core_clk);
		rst = 1'b1;
		repeat (8) @(negedge core_clk);
		rst = 1'b0;
		dflt();
		foreach (rows[i]) begin
			host_u.wr(rows[i].a, rows[i].w);
			rchk(rows[i].a, rows[i].m, rows[i].e);
			if (rows[i].a == 8'h02) begin
				cmp("select", rows[i].w, {psel, nsel});
			end
		end
		mchk(1'b1, 2'b11, 7'h6B);
		mchk(1'b0, 2'b01, 7'h7F);
		mchk(1'b1, 2'b10, 7'h55);
		mchk(1'b1, 2'b00, 7'h3C);
		mchk(1'b0, 2'b11, 7'h00);
		rst = 1'b1;
		@(negedge core_clk);
		rst = 1'b0;
		dflt();
		report_and_stop();
	end

	// Watchdog: the sequence needs about 120 cycles, so 2000 cycles means a hang.
	initial begin
		#50us;
		miscompares++;
		report_and_stop();
	end
endmodule : test_ais_regs
`default_nettype wire

// ### hw/ais_pkg.sv
// Types used by the ID/status/mux register bank; its input synchroniser keeps its own.
// Assumes ais_regs_map.svh is visible to every file that uses these types.
`default_nettype none

package ais_pkg;

	// Register state of the bank.
	typedef struct packed {
		logic [7:0] status;
		logic [3:0] pos_sel;
		logic [3:0] neg_sel;
		logic [7:0] rdata;
		logic rvalid;
	} ais_bank_t;

	// Monitor inputs in one bundle: four rail flags, two reference flags, not-ready.
	typedef logic [6:0] ais_mon_t;

endpackage : ais_pkg

`default_nettype wire

// ### hw/ais_regs.sv
// Identification, fault status and input select registers of a delta-sigma converter.
// Assumes the serial command decoder presents register reads and writes as one-cycle strobes.
`include "ais_regs_map.svh"
`default_nettype none

module ais_regs #(
	parameter logic [2:0] MODEL_CODE = 3'h6, // Arbitrary value, set per product variant.
	parameter logic [4:0] ID_RESERVED = 5'h00 // Arbitrary value for the reserved bits.
) (
	// Clock and reset.
	input wire logic core_clk_i,
	input wire logic rst_i,
	// Register command port from the serial decoder.
	input wire logic reg_rd_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	output logic reg_rvalid_o,
	// Monitor enables from the reference and excitation registers.
	input wire logic rail_monitor_enable_i,
	input wire logic [1:0] reference_monitor_enable_i,
	// Analog comparator levels and start-up state.
	input wire logic pos_out_high_rail_i,
	input wire logic pos_out_low_rail_i,
	input wire logic neg_out_high_rail_i,
	input wire logic neg_out_low_rail_i,
	input wire logic reference_third_supply_i,
	input wire logic reference_missing_i,
	input wire logic not_ready_i,
	// Input multiplexer selects.
	output logic [3:0] positive_input_select_o,
	output logic [3:0] negative_input_select_o
);
	import ais_pkg::*;

	ais_bank_t bank_reg;
	ais_bank_t bank_next;
	ais_mon_t mon_raw;
	ais_mon_t mon;
	logic [7:0] status_live;
	logic [7:0] id_value;

	// Bring comparator levels into the clock domain.
	assign mon_raw = {not_ready_i, pos_out_high_rail_i, pos_out_low_rail_i,
		neg_out_high_rail_i, neg_out_low_rail_i, reference_third_supply_i, reference_missing_i};

	ais_sync #(
		.WIDTH(7)
	) u_sync (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.async_i(mon_raw),
		.sync_o(mon)
	);

	// Fixed identification value; nothing can write it.
	assign id_value = {ID_RESERVED, MODEL_CODE};

	// Next state: live flags, sticky power-on flag, select writes and read data.
	always_comb begin
		bank_next = bank_reg;
		bank_next.rvalid = reg_rd_i;
		status_live = bank_reg.status;
		// Ready indicator follows start-up state, low means ready.
		status_live[`AIS_ST_NOT_READY] = mon[6];
		// Rail flags are forced low unless the rail monitor is on.
		status_live[`AIS_ST_RAIL_HI:`AIS_ST_RAIL_LO] =
			rail_monitor_enable_i ? mon[5:2] : 4'h0;
		// Missing reference check runs for any non-zero enable, third-supply check needs bit 1.
		status_live[`AIS_ST_REF_THIRD] = reference_monitor_enable_i[1] & mon[1];
		status_live[`AIS_ST_REF_MISSING] = (|reference_monitor_enable_i) & mon[0];
		if (reg_wr_i && reg_addr_i == `AIS_ADDR_STATUS) begin
			// Only the power-on flag takes the written value.
			status_live[`AIS_ST_POR] = reg_wdata_i[`AIS_ST_POR];
		end
		bank_next.status = status_live;
		if (reg_wr_i && reg_addr_i == `AIS_ADDR_INSEL) begin
			// Codes above eleven are reserved but stored as written.
			bank_next.pos_sel = reg_wdata_i[7:4];
			bank_next.neg_sel = reg_wdata_i[3:0];
		end
		// Read data is returned one cycle after the read strobe.
		if (reg_rd_i) begin
			case (reg_addr_i)
				`AIS_ADDR_ID: bank_next.rdata = id_value;
				`AIS_ADDR_STATUS: bank_next.rdata = bank_reg.status;
				`AIS_ADDR_INSEL: bank_next.rdata = {bank_reg.pos_sel, bank_reg.neg_sel};
				default: bank_next.rdata = 8'h00;
			endcase
		end
	end

	// Register the bank; reset restores every default and raises the power-on flag.
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			bank_reg.status <= `AIS_STATUS_RESET;
			bank_reg.pos_sel <= `AIS_POS_SEL_RESET;
			bank_reg.neg_sel <= `AIS_NEG_SEL_RESET;
			bank_reg.rdata <= 8'h00;
			bank_reg.rvalid <= 1'b0;
		end else begin
			bank_reg <= bank_next;
		end
	end

	// Outputs come straight from the bank flip-flops.
	assign reg_rdata_o = bank_reg.rdata;
	assign reg_rvalid_o = bank_reg.rvalid;
	assign positive_input_select_o = bank_reg.pos_sel;
	assign negative_input_select_o = bank_reg.neg_sel;

	// Checks on the register bank behaviour.
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);

	sequence rd_id_s;
		reg_rd_i && reg_addr_i == `AIS_ADDR_ID;
	endsequence

	sequence wr_insel_s;
		reg_wr_i && reg_addr_i == `AIS_ADDR_INSEL;
	endsequence

	chk_id_read_value: assert property (rd_id_s |=> reg_rvalid_o && reg_rdata_o == id_value)
		else $error("ID read returned wrong value.");

	chk_id_model_low: assert property (rd_id_s |=> reg_rdata_o[2:0] == MODEL_CODE)
		else $error("Model code not in low ID bits.");

	chk_por_sticky_flag: assert property ($fell(bank_reg.status[`AIS_ST_POR]) |->
		$past(reg_wr_i) && $past(reg_addr_i) == `AIS_ADDR_STATUS)
		else $error("Power-on flag cleared without status write.");

	chk_status_reset_val: assert property (disable iff (1'b0)
		rst_i |-> bank_reg.status == `AIS_STATUS_RESET)
		else $error("Status not 80h during reset.");

	chk_ready_bit_track: assert property (##1 bank_reg.status[`AIS_ST_NOT_READY] == $past(mon[6]))
		else $error("Ready bit does not follow start-up state.");

	chk_rail_flag_gate: assert property (!rail_monitor_enable_i |=>
		bank_reg.status[`AIS_ST_RAIL_HI:`AIS_ST_RAIL_LO] == 4'h0)
		else $error("Rail flag set while rail monitor off.");

	chk_rail_flag_pass: assert property (rail_monitor_enable_i |=>
		bank_reg.status[5:2] == $past(mon[5:2]))
		else $error("Rail flags do not follow comparators.");

	chk_ref_third_flag: assert property (##1 bank_reg.status[`AIS_ST_REF_THIRD] ==
		($past(reference_monitor_enable_i[1]) && $past(mon[1])))
		else $error("Third-supply reference flag wrong.");

	chk_ref_missing_flag: assert property (##1 bank_reg.status[`AIS_ST_REF_MISSING] ==
		(($past(reference_monitor_enable_i) != 2'h0) && $past(mon[0])))
		else $error("Missing reference flag wrong.");

	chk_insel_write_load: assert property (wr_insel_s |=>
		{positive_input_select_o, negative_input_select_o} == $past(reg_wdata_i))
		else $error("Input select write not stored.");

	chk_ro_write_ignore: assert property (reg_wr_i && reg_addr_i != `AIS_ADDR_INSEL |=>
		$stable({positive_input_select_o, negative_input_select_o}))
		else $error("Select changed on write to another address.");

	// Read path checks: every strobe answered once, with the value held at the strobe.
	sequence rd_status_s;
		reg_rd_i && reg_addr_i == `AIS_ADDR_STATUS;
	endsequence

	sequence rd_insel_s;
		reg_rd_i && reg_addr_i == `AIS_ADDR_INSEL;
	endsequence

	sequence wr_status_s;
		reg_wr_i && reg_addr_i == `AIS_ADDR_STATUS;
	endsequence

	chk_rvalid_after_read: assert property (reg_rd_i |=> reg_rvalid_o)
		else $error("Read strobe not answered.");

	chk_rvalid_one_shot: assert property (!reg_rd_i |=> !reg_rvalid_o)
		else $error("Read valid without a read strobe.");

	chk_status_read_value: assert property (rd_status_s |=>
		reg_rdata_o == $past(bank_reg.status))
		else $error("Status read returned wrong value.");

	chk_insel_read_value: assert property (rd_insel_s |=>
		reg_rdata_o == {$past(positive_input_select_o), $past(negative_input_select_o)})
		else $error("Input select read returned wrong value.");

	chk_unmapped_read_zero: assert property (reg_rd_i && reg_addr_i > `AIS_ADDR_INSEL |=>
		reg_rdata_o == 8'h00)
		else $error("Unmapped read returned non-zero data.");

	// Power-on flag checks: a zero write clears it, and only a one write raises it again.
	chk_por_write_clear: assert property (wr_status_s ##0 !reg_wdata_i[`AIS_ST_POR] |=>
		!bank_reg.status[`AIS_ST_POR])
		else $error("Power-on flag not cleared by status write.");

	chk_por_no_self_set: assert property ($rose(bank_reg.status[`AIS_ST_POR]) |->
		$past(reg_wr_i) && $past(reg_addr_i) == `AIS_ADDR_STATUS &&
		$past(reg_wdata_i[`AIS_ST_POR]))
		else $error("Power-on flag rose without reset or write.");

endmodule : ais_regs

`default_nettype wire

// ### hw/ais_regs_map.svh
// Offsets, field positions, reset values and timing counts of the ID/status/mux register bank.
// Assumes the including file is compiled after this header and uses the names verbatim.
`ifndef AIS_REGS_MAP_SVH
`define AIS_REGS_MAP_SVH

// Register addresses on the command port.
`define AIS_ADDR_ID 8'h00
`define AIS_ADDR_STATUS 8'h01
`define AIS_ADDR_INSEL 8'h02

// Reset values.
`define AIS_STATUS_RESET 8'h80
`define AIS_INSEL_RESET 8'h01
`define AIS_POS_SEL_RESET 4'h0
`define AIS_NEG_SEL_RESET 4'h1

// Status field positions.
`define AIS_ST_POR 7
`define AIS_ST_NOT_READY 6
`define AIS_ST_RAIL_HI 5
`define AIS_ST_RAIL_LO 2
`define AIS_ST_REF_THIRD 1
`define AIS_ST_REF_MISSING 0

// Highest legal input select code.
`define AIS_SEL_MAX 4'hB

// Shift stages in each pin synchroniser, not counting the output level flip-flop.
`define AIS_SYNC_STAGES 3

`endif

// ### hw/ais_sync.sv
// Three-stage synchroniser for the analog monitor inputs, one chain per bit.
// Assumes inputs come from outside the core clock domain; output changes once stages agree.
`default_nettype none

module ais_sync #(
	parameter int WIDTH = 7
) (
	// Clock and reset.
	input wire logic core_clk_i,
	input wire logic rst_i,
	// Raw and filtered levels.
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] level;
	} ais_sync_t;

	ais_sync_t sync_reg;
	ais_sync_t sync_next;
	logic [WIDTH-1:0] agree;

	// Per bit, the second and third stages agree once a level has held for two samples.
	genvar b;
	generate
		for (b = 0; b < WIDTH; b++) begin : g_bit
			assign agree[b] = sync_reg.s2[b] == sync_reg.s3[b];
		end
	endgenerate

	// Shift each bit along its chain; the first stage feeds only the second.
	always_comb begin
		sync_next = sync_reg;
		sync_next.s1 = async_i;
		sync_next.s2 = sync_reg.s1;
		sync_next.s3 = sync_reg.s2;
		// Take the new level only where the last two stages agree, otherwise hold it.
		sync_next.level = (sync_reg.s3 & agree) | (sync_reg.level & ~agree);
	end

	// Register the whole chain in one place; reset clears every stage and the level.
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sync_reg <= '0;
		end else begin
			sync_reg <= sync_next;
		end
	end

	assign sync_o = sync_reg.level;

endmodule : ais_sync

`default_nettype wire
